/* hdl/ircm_consts.vh */
/*
  Constants for the infrared carrier modulator core: register offsets,
  field positions, reset values and timing figures.
  Assumes inclusion by bare name from design files under hdl/.
*/
`ifndef IRCM_CONSTS_VH
`define IRCM_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define IRCM_OFS_CTRL 12'h000
`define IRCM_OFS_CARRIER_PRI 12'h004
`define IRCM_OFS_CARRIER_SEC 12'h008
`define IRCM_OFS_MARK 12'h00C
`define IRCM_OFS_SPACE 12'h010
`define IRCM_OFS_STATUS 12'h014

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define IRCM_CTRL_GEN_EN 0
`define IRCM_CTRL_FORCE 1
`define IRCM_CTRL_DUAL 2
`define IRCM_CTRL_EXGAP 3
`define IRCM_CTRL_PRESC_LO 4
`define IRCM_CTRL_PRESC_HI 5
`define IRCM_CTRL_LATCH 6
`define IRCM_CTRL_MASK 32'h0000007F

// ----------------------------------------
// Carrier count fields (high in low byte, low in next byte)
// ----------------------------------------
`define IRCM_CNT_HIGH_LO 0
`define IRCM_CNT_HIGH_HI 7
`define IRCM_CNT_LOW_LO 8
`define IRCM_CNT_LOW_HI 15

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define IRCM_RST_CTRL 7'h00
`define IRCM_RST_COUNT 8'h01
`define IRCM_RST_PERIOD 16'h0000
`define IRCM_CNT_RESTART 8'h01
`define IRCM_MOD_DIV 3'h7

`endif

/* hdl/ircm_carrier_gen.v */
/*
  Carrier generator: 8-bit high/low up counter with a primary and a
  secondary count set.
  Assumes tick is a one-cycle pulse at the prescaled rate and that all
  count values are non-zero.
*/
`timescale 1ns/1ps
`include "ircm_consts.vh"

module ircm_carrier_gen #(
  parameter CW = 8
) (
  input wire pclk,
  input wire presetn,
  input wire run,
  input wire tick,
  input wire use_sec,
  input wire [CW-1:0] pri_high,
  input wire [CW-1:0] pri_low,
  input wire [CW-1:0] sec_high,
  input wire [CW-1:0] sec_low,
  output reg carrier_q,
  output reg period_end_q
);

  reg [CW-1:0] cnt_q;
  reg high_sel_q;
  wire [CW-1:0] cmp_val;
  wire [CW-1:0] cnt_inc;
  wire match;

  // Selected set and half of the pair
  assign cmp_val = use_sec ? (high_sel_q ? sec_high : sec_low) :
                   (high_sel_q ? pri_high : pri_low);
  assign cnt_inc = cnt_q + {{(CW-1){1'b0}}, 1'b1};
  assign match = (cnt_q == cmp_val);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= {{(CW-1){1'b0}}, 1'b1};
      high_sel_q <= 1'b1;
      carrier_q <= 1'b0;
      period_end_q <= 1'b0;
    end else begin
      period_end_q <= 1'b0;
      if (!run) begin
        // Fresh start each time the generator is re-enabled
        cnt_q <= `IRCM_CNT_RESTART;
        high_sel_q <= 1'b1;
        carrier_q <= 1'b0;
      end else if (tick) begin
        if (match) begin
          cnt_q <= `IRCM_CNT_RESTART;
          high_sel_q <= ~high_sel_q;
          carrier_q <= high_sel_q;
          period_end_q <= ~high_sel_q;
        end else begin
          cnt_q <= cnt_inc;
        end
      end
    end
  end

endmodule

/* hdl/ircm_core.v */
/*
  Infrared carrier modulator core: APB register slave, prescaler,
  carrier generator, modulator down counter and output pin stage.
  Assumes a single 125 MHz APB clock; APB master follows the usual
  setup/access sequence. Pin output is active high.
*/
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`include "ircm_consts.vh"

module ircm_core #(
  parameter CW = 8,
  parameter MW = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg infrared_out_pin
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  reg [6:0] ctrl_q;
  reg [2*CW-1:0] cpri_q;
  reg [2*CW-1:0] csec_q;
  reg [MW-1:0] mark_buf_q;
  reg [MW-1:0] space_buf_q;
  wire access;
  wire wr;
  wire hit;
  reg [31:0] rdata_d;

  wire generator_enable;
  wire carrier_force_level_mode;
  wire dual_freq_select;
  wire extended_gap_enable;
  wire [1:0] clock_prescale_select;
  wire pin_latch_value;

  assign generator_enable = ctrl_q[`IRCM_CTRL_GEN_EN];
  assign carrier_force_level_mode = ctrl_q[`IRCM_CTRL_FORCE];
  assign dual_freq_select = ctrl_q[`IRCM_CTRL_DUAL];
  assign extended_gap_enable = ctrl_q[`IRCM_CTRL_EXGAP];
  assign clock_prescale_select = ctrl_q[`IRCM_CTRL_PRESC_HI:`IRCM_CTRL_PRESC_LO];
  assign pin_latch_value = ctrl_q[`IRCM_CTRL_LATCH];

  // Modulator state, declared early for the status read
  reg active_q;
  reg gate_q;
  reg sec_set_q;
  reg exgap_cycle_q;
  reg mod_out_q;

  assign access = psel && penable;
  assign wr = access && pwrite;
  assign hit = (paddr == `IRCM_OFS_CTRL) || (paddr == `IRCM_OFS_CARRIER_PRI) ||
               (paddr == `IRCM_OFS_CARRIER_SEC) || (paddr == `IRCM_OFS_MARK) ||
               (paddr == `IRCM_OFS_SPACE) || (paddr == `IRCM_OFS_STATUS);

  always @* begin
    rdata_d = 32'h00000000;
    case (paddr)
      `IRCM_OFS_CTRL: rdata_d = {25'h0000000, ctrl_q};
      `IRCM_OFS_CARRIER_PRI: rdata_d = {16'h0000, cpri_q};
      `IRCM_OFS_CARRIER_SEC: rdata_d = {16'h0000, csec_q};
      `IRCM_OFS_MARK: rdata_d = {16'h0000, mark_buf_q};
      `IRCM_OFS_SPACE: rdata_d = {16'h0000, space_buf_q};
      `IRCM_OFS_STATUS: rdata_d = {27'h0000000, mod_out_q, exgap_cycle_q,
                                   sec_set_q, gate_q, active_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `IRCM_RST_CTRL;
      cpri_q <= {`IRCM_RST_COUNT, `IRCM_RST_COUNT};
      csec_q <= {`IRCM_RST_COUNT, `IRCM_RST_COUNT};
      mark_buf_q <= `IRCM_RST_PERIOD;
      space_buf_q <= `IRCM_RST_PERIOD;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && !hit;
      prdata <= (access && !pready && !pwrite) ? rdata_d : 32'h00000000;
      if (wr && !pready) begin
        case (paddr)
          `IRCM_OFS_CTRL: ctrl_q <= pwdata[6:0];
          `IRCM_OFS_CARRIER_PRI: cpri_q <= pwdata[2*CW-1:0];
          `IRCM_OFS_CARRIER_SEC: csec_q <= pwdata[2*CW-1:0];
          `IRCM_OFS_MARK: mark_buf_q <= pwdata[MW-1:0];
          `IRCM_OFS_SPACE: space_buf_q <= pwdata[MW-1:0];
          default: ctrl_q <= ctrl_q;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  reg [2:0] pre_q;
  reg [2:0] pre_mask;
  wire pre_tick;

  always @* begin
    case (clock_prescale_select)
      2'h0: pre_mask = 3'h0;
      2'h1: pre_mask = 3'h1;
      2'h2: pre_mask = 3'h3;
      default: pre_mask = 3'h7;
    endcase
  end

  assign pre_tick = active_q && ((pre_q & pre_mask) == pre_mask);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 3'h0;
    end else if (!active_q) begin
      pre_q <= 3'h0;
    end else begin
      pre_q <= pre_q + 3'h1;
    end
  end

  // ----------------------------------------
  // Carrier generator
  // ----------------------------------------
  wire carrier_raw;
  wire carrier_period_end;
  wire carrier_run;
  wire carrier_signal;

  // Clock gating is modelled as a run qualifier; no gated clock is built
  assign carrier_run = active_q && !carrier_force_level_mode;

  ircm_carrier_gen #(
    .CW(CW)
  ) u_carrier (
    .pclk(pclk),
    .presetn(presetn),
    .run(carrier_run),
    .tick(pre_tick),
    .use_sec(sec_set_q),
    .pri_high(cpri_q[`IRCM_CNT_HIGH_HI:`IRCM_CNT_HIGH_LO]),
    .pri_low(cpri_q[`IRCM_CNT_LOW_HI:`IRCM_CNT_LOW_LO]),
    .sec_high(csec_q[`IRCM_CNT_HIGH_HI:`IRCM_CNT_HIGH_LO]),
    .sec_low(csec_q[`IRCM_CNT_LOW_HI:`IRCM_CNT_LOW_LO]),
    .carrier_q(carrier_raw),
    .period_end_q(carrier_period_end)
  );

  assign carrier_signal = carrier_force_level_mode ? 1'b1 : carrier_raw;

  // ----------------------------------------
  // Modulator
  // ----------------------------------------
  reg [2:0] mdiv_q;
  reg [MW:0] down_q;
  reg [MW-1:0] space_q;
  wire fsk_mode;
  wire mod_tick;
  wire cycle_end;
  wire [MW-1:0] down_cpl;
  wire [MW:0] down_nxt;

  assign fsk_mode = dual_freq_select && !carrier_force_level_mode;
  // Carrier periods in dual mode, prescaled clock over eight otherwise
  assign mod_tick = fsk_mode ? carrier_period_end :
                    (pre_tick && mdiv_q == `IRCM_MOD_DIV);
  assign down_nxt = down_q - {{MW{1'b0}}, 1'b1};
  assign down_cpl = ~down_nxt[MW-1:0];
  // Compare the value the tick would leave; a zero space ends at underflow
  assign cycle_end = mod_tick && down_nxt[MW] && (down_cpl == space_q);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q <= 1'b0;
      mdiv_q <= 3'h0;
      down_q <= {(MW+1){1'b0}};
      space_q <= `IRCM_RST_PERIOD;
      gate_q <= 1'b0;
      sec_set_q <= 1'b0;
      exgap_cycle_q <= 1'b0;
    end else if (!active_q) begin
      mdiv_q <= 3'h0;
      gate_q <= 1'b0;
      sec_set_q <= 1'b0;
      if (generator_enable) begin
        active_q <= 1'b1;
        down_q <= {1'b0, mark_buf_q};
        space_q <= space_buf_q;
        exgap_cycle_q <= extended_gap_enable;
        gate_q <= 1'b1;
      end
    end else begin
      if (pre_tick) begin
        mdiv_q <= mdiv_q + 3'h1;
      end
      if (cycle_end) begin
        if (!generator_enable) begin
          active_q <= 1'b0;
          gate_q <= 1'b0;
        end else begin
          down_q <= {1'b0, mark_buf_q};
          space_q <= space_buf_q;
          exgap_cycle_q <= extended_gap_enable;
          gate_q <= 1'b1;
          if (fsk_mode) begin
            sec_set_q <= ~sec_set_q;
          end
        end
      end else if (mod_tick) begin
        // Counts mark+1 ticks down to underflow, then space ticks more
        down_q <= down_nxt;
        if (!down_q[MW] && down_q[MW-1:0] == {MW{1'b0}}) begin
          gate_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Transmitter output
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_out_q <= 1'b0;
      infrared_out_pin <= 1'b0;
    end else begin
      // Baseband: carrier_signal is constant high, so pin follows gate unless exgap_cycle_q blanks the cycle
      mod_out_q <= active_q && gate_q && !exgap_cycle_q && carrier_signal;
      if (generator_enable || active_q) begin
        infrared_out_pin <= mod_out_q;
      end else begin
        infrared_out_pin <= pin_latch_value;
      end
    end
  end

endmodule

/* test/ircm_props.sv */
/*
  Port checker for ircm_core: APB answer timing and pin latch path.
  Assumes it is bound to ircm_core and sees only its ports.
*/
`timescale 1ns/1ps
module ircm_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire infrared_out_pin
);
  // ------------------------------
  // Shadow of control writes
  // ------------------------------
  reg [6:0] ctrl_q;
  reg ever_en_q;
  wire ctrl_wr = psel && penable && pready && pwrite && paddr == 12'h000;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 7'h00;
      ever_en_q <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl_q <= pwdata[6:0];
      ever_en_q <= ever_en_q | pwdata[0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_done; psel && penable && pready; endsequence
  AST_ANSWER: assert property (s_wait |=> s_done) else $error("late answer");
  AST_PULSE: assert property (pready |=> !pready) else $error("long ready");
  AST_INPHASE: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
  AST_ERR: assert property (pslverr |-> pready) else $error("stray error");
  AST_UNMAP: assert property (pready && paddr > 12'h014 |-> pslverr) else $error("no error");
  AST_MAPPED: assert property (pready && paddr <= 12'h014 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("false error");
  AST_RDZERO: assert property (!pready |-> prdata == 32'h00000000) else $error("data idle");
  AST_LATCH: assert property (!ever_en_q |-> infrared_out_pin == ctrl_q[6])
    else $error("pin not latch");
  AST_RESET: assert property ($rose(presetn) |-> !infrared_out_pin && !pready)
    else $error("reset output");
endmodule
bind ircm_core ircm_props props_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .infrared_out_pin(infrared_out_pin));

/* test/ircm_emitter.sv */
/*
  Emitter model: measures pulse widths seen on the infrared pin.
  Assumes the pin changes just after rising edges of pclk.
*/
`timescale 1ns/1ps
module ircm_emitter (
  input wire pclk,
  input wire clr,
  input wire pin,
  output reg [15:0] first_high,
  output reg [15:0] first_low,
  output reg [15:0] max_high,
  output reg [15:0] rises
);
  // ------------------------------
  // Run-length measurement
  // ------------------------------
  reg [15:0] run;
  reg last;
  always @(posedge pclk) begin
    last <= pin;
    if (clr) begin
      run <= 16'h0000;
      rises <= 16'h0000;
      max_high <= 16'h0000;
      first_high <= 16'h0000;
      first_low <= 16'h0000;
    end else if (pin != last) begin
      run <= 16'h0001;
      if (!pin && rises == 16'h0001) first_high <= run;
      if (pin && rises == 16'h0001) first_low <= run;
      if (!pin && run > max_high) max_high <= run;
      if (pin) rises <= rises + 16'h0001;
    end else begin
      run <= run + 16'h0001;
    end
  end
endmodule

/* test/ircm_core_tb.sv */
/*
  Testbench for ircm_core: APB tasks, register values and pin modes.
  Assumes the emitter model and the bound checker compile first.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module ircm_core_tb;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clr = 1'b1, err;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000, rd;
  wire [31:0] prdata;
  wire pready, pslverr, pin;
  wire [15:0] fh, fl, mh, rises;
  integer fails = 0, num_checks = 0, i;
  always #4 pclk = ~pclk;
  ircm_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .infrared_out_pin(pin));
  ircm_emitter emit_u (.pclk(pclk), .clr(clr), .pin(pin), .first_high(fh), .first_low(fl),
    .max_high(mh), .rises(rises));
  // ------------------------------
  // Bus and wait tasks
  // ------------------------------
  task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
        @(negedge pclk);
        n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) fails++;
    end
  endtask
  task poll(input integer b, input reg v);
    integer n;
    begin
      n = 0;
      do begin
        apb(1'b0, 12'h014, 32'h00000000);
        n++;
      end while (rd[b] !== v && n < 500);
      if (n >= 500) fails++;
    end
  endtask
  task start(input reg [31:0] c);
    begin
      poll(0, 1'b0);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      apb(1'b1, 12'h000, c); // Data words set first
      for (i = 0; i < 5000 && rises < 16'h0003; i++) @(posedge pclk);
    end
  endtask
  task complete_run;
    begin
      $display("checks=%0d mismatches=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    #600000;
    fails++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    clr <= 1'b0;
    for (i = 0; i < 7; i++) begin
      apb(1'b0, 12'(i * 4), 32'h00000000);
      `CHK(rd, (i == 1 || i == 2) ? 32'h00000101 : 32'h00000000)
      `CHK(err, i == 6)
    end
    apb(1'b1, 12'h008, 32'hFFFF0103);
    apb(1'b0, 12'h008, 32'h00000000);
    `CHK(rd, 32'h00000103)
    apb(1'b1, 12'h000, 32'h00000040);
    repeat (2) @(posedge pclk);
    `CHK(pin, 1'b1)
    // Time mode: carrier high 2, low 3 inside a long mark
    apb(1'b1, 12'h004, 32'h00000203); // Non-zero counts only
    apb(1'b1, 12'h00C, 32'h00000010);
    apb(1'b1, 12'h010, 32'h00000004);
    start(32'h00000001);
    `CHK(fh, 16'h0002)
    `CHK(fl, 16'h0003)
    // Dual mode swaps between the primary and secondary sets after each two-period cycle
    apb(1'b1, 12'h004, 32'h00000201);
    apb(1'b1, 12'h008, 32'h00000301);
    apb(1'b1, 12'h00C, 32'h00000001);
    apb(1'b1, 12'h010, 32'h00000000);
    apb(1'b1, 12'h000, 32'h00000000);
    start(32'h00000005);
    for (i = 0; i < 5000 && rises < 16'h000C; i++) @(posedge pclk);
    `CHK(fh, 16'h0002)
    `CHK(mh, 16'h0003)
    // Baseband at every prescale code; dual bit ignored on the last
    apb(1'b1, 12'h00C, 32'h00000002);
    apb(1'b1, 12'h010, 32'h00000001);
    for (integer p = 0; p < 4; p++) begin
      apb(1'b1, 12'h000, 32'h00000000);
      start(32'h00000003 | (p << 4) | (p == 3 ? 32'h4 : 32'h0));
      `CHK(fh, 16'(24 << p))
      `CHK(fl, 16'(8 << p))
    end
    // Extended gap: once latched, no more marks
    apb(1'b1, 12'h000, 32'h0000003F);
    poll(3, 1'b1);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (700) @(posedge pclk);
    `CHK(rises, 16'h0000)
    apb(1'b1, 12'h000, 32'h00000040);
    poll(0, 1'b0);
    repeat (3) @(posedge pclk);
    `CHK(pin, 1'b1)
    complete_run;
  end
endmodule
